// >>> hdl/scd_pkg.sv
// Purpose: Shared constants for the stepper command decoder
// Assumes: ref_clk at 100 MHz
// Notes:   Host map, code-byte fields, operand counts, error codes
package scd_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS   = 10;
	localparam int TICK_NS  = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICK_W   = $clog2(TICK_CYC);

	// ****************************************
	// Host port map and status bits
	// ****************************************
	localparam logic ADDR_DATA = 1'b0;
	localparam logic ADDR_CTRL = 1'b1;
	localparam int   ST_OBF    = 0;
	localparam int   ST_IBF    = 1;
	localparam int   ST_ACT1   = 2;
	localparam int   ST_ACT2   = 3;
	localparam int   ST_CMD1   = 4;
	localparam int   ST_CMD2   = 5;
	localparam int   ST_ERR    = 6;

	// ****************************************
	// Code byte fields
	// ****************************************
	localparam int         F_OPT    = 7;
	localparam int         F_AXIS   = 5;
	localparam int         F_IRQ    = 4;
	localparam int         F_DIR    = 3;
	localparam logic [1:0] CLS_INIT = 2'h0;
	localparam logic [1:0] CLS_MOVE = 2'h1;
	localparam logic [1:0] CLS_READ = 2'h2;
	localparam logic [1:0] CLS_AUX  = 2'h3;
	localparam logic [2:0] MV_STOP  = 3'h0;
	localparam logic [2:0] MV_DSTOP = 3'h1;
	localparam logic [2:0] MV_STEP  = 3'h2;
	localparam logic [2:0] MV_RAMP  = 3'h3;
	localparam logic [2:0] MV_CONST = 3'h4;
	localparam logic [2:0] MV_CRUN  = 3'h5;
	localparam logic [2:0] MV_HIGH  = 3'h6;
	localparam logic [2:0] MV_ORIG  = 3'h7;
	localparam logic [3:0] RD_END   = 4'h0;
	localparam logic [3:0] RD_CIN   = 4'h1;
	localparam logic [3:0] RD_OUT   = 4'h2;
	localparam logic [3:0] RD_REM   = 4'h3;
	localparam logic [3:0] RD_SWF   = 4'h4;
	localparam logic [3:0] RD_HOLD  = 4'h5;
	localparam logic [3:0] RD_ERR   = 4'h6;
	localparam logic [3:0] AX_EXOFF = 4'h0;
	localparam logic [3:0] AX_OUT   = 4'h1;
	localparam logic [3:0] AX_IN    = 4'h2;

	// ****************************************
	// Operand counts, errors, reset values
	// ****************************************
	localparam logic [2:0] LEN_INIT   = 3'h4;
	localparam logic [2:0] LEN_RAMP   = 3'h3;
	localparam logic [2:0] LEN_CONST  = 3'h4;
	localparam logic [2:0] LEN_RATE   = 3'h1;
	localparam logic [2:0] LEN_SWF    = 3'h2;
	localparam logic [2:0] LEN_HOLD   = 3'h1;
	localparam logic [3:0] ERR_NONE   = 4'h0;
	localparam logic [3:0] ERR_UNDEF  = 4'h1;
	localparam logic [3:0] ERR_NOCODE = 4'h2;
	localparam logic [3:0] ERR_WAIT   = 4'h3;
	localparam logic [3:0] ERR_NOINIT = 4'h4;
	localparam logic [3:0] ERR_BUSY   = 4'h5;
	localparam logic [1:0] AUX_RST    = 2'h3;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_INIT,
		OP_MOVE,
		OP_SWF,
		OP_HOLD
	} scd_op_t;

endpackage : scd_pkg

// >>> hdl/scd_top.sv
// Purpose: Decodes host code and data bytes for a two-axis stepper
// Assumes: Pulse generators and excitation logic share ref_clk
// Notes:   Code-only moves fire at once, others after their last byte
`timescale 1ns/1ns

module scd_top
	import scd_pkg::*;
(
	input  wire logic             ref_clk,         // 100 MHz clock
	input  wire logic             rst_n,           // Sync reset
	input  wire logic             host_addr,       // 0 data, 1 code/status
	input  wire logic [7:0]       host_wdata,      // Write byte
	input  wire logic             host_wr,         // Write strobe
	input  wire logic             host_rd,         // Read strobe
	output logic      [7:0]       host_rdata,      // Read byte
	input  wire logic             axis_one_active, // Axis 1 stepping
	input  wire logic             axis_two_active, // Axis 2 stepping
	input  wire logic [1:0][7:0]  end_stat,        // End status
	input  wire logic [1:0][7:0]  ctl_in_stat,     // Control inputs
	input  wire logic [1:0][7:0]  out_stat,        // Output status
	input  wire logic [1:0][23:0] remain_cnt,      // Pulses left
	input  wire logic [1:0]       aux_in_pin,      // Auxiliary inputs
	output logic      [1:0]       aux_out_pin,     // Auxiliary outputs
	output logic      [1:0][5:0]  init_cfg,        // Bits 5:0 of code
	output logic      [1:0][7:0]  init_start_rate, // Start-up rate
	output logic      [1:0][7:0]  init_high_rate,  // High-speed rate
	output logic      [1:0][15:0] init_ramp_cnt,   // Ramp pulses
	output logic      [1:0]       init_done,       // Axis configured
	output logic      [1:0]       mv_strb,         // Move issue pulse
	output logic      [2:0]       mv_code,         // Move kind
	output logic                  mv_dir,          // Direction level
	output logic                  mv_irq,          // Interrupt at end
	output logic                  mv_opt,          // Pulse output option
	output logic      [7:0]       mv_rate,         // Fixed rate
	output logic      [23:0]      mv_count,        // Pulse count
	output logic      [1:0]       phase_en,        // Excitation gate
	output logic      [1:0]       hold_out         // Motor hold
);

	// ****************************************
	// Operand count of an accepted code
	// ****************************************
	function automatic logic [2:0] scd_len(input logic [7:0] c);
		logic [2:0] n;
		n = 3'h0;
		case (c[7:6])
			CLS_INIT: n = LEN_INIT;
			CLS_READ: begin
				if (c[3:0] == RD_SWF)
					n = LEN_SWF;
				else if (c[3:0] == RD_HOLD)
					n = LEN_HOLD;
			end
			default: begin
				if (c[2:0] == MV_RAMP)
					n = LEN_RAMP;
				else if (c[2:0] == MV_CONST)
					n = LEN_CONST;
				else if (c[2:0] == MV_CRUN || c[2:0] == MV_ORIG)
					n = LEN_RATE;
			end
		endcase
		return n;
	endfunction : scd_len

	// ****************************************
	// Host byte latch
	// ****************************************
	logic       input_full_flag;
	logic       in_cmd_q;
	logic [7:0] in_byte_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			input_full_flag <= 1'b0;
			in_cmd_q        <= 1'b0;
			in_byte_q       <= 8'h00;
		end else begin
			input_full_flag <= host_wr;
			if (host_wr) begin
				in_cmd_q  <= (host_addr == ADDR_CTRL);
				in_byte_q <= host_wdata;
			end
		end
	end

	// ****************************************
	// Code decode
	// ****************************************
	wire       cmd_ev   = input_full_flag & in_cmd_q;
	wire       dat_ev   = input_full_flag & ~in_cmd_q;
	wire [1:0] cls      = in_byte_q[7:6];
	wire       ax       = in_byte_q[F_AXIS];
	wire [2:0] sub3     = in_byte_q[2:0];
	wire [3:0] sub4     = in_byte_q[3:0];
	wire       b4       = in_byte_q[F_IRQ];
	wire       b43      = in_byte_q[F_IRQ] | in_byte_q[F_DIR];
	wire       p_move   = (sub3 == MV_RAMP) | (sub3 == MV_HIGH);
	wire       is_init  = (cls == CLS_INIT);
	wire       is_stop  = (cls == CLS_MOVE) & ~b43 &
	                      ((sub3 == MV_STOP) | (sub3 == MV_DSTOP));
	wire       is_move  = ((cls == CLS_MOVE) & (sub3[2] | sub3[1])) |
	                      ((cls == CLS_AUX) & p_move) | is_stop;
	wire       rd_grp   = (cls == CLS_READ) & ~b4;
	wire       is_read  = rd_grp & ((sub4 <= RD_REM) | (sub4 == RD_ERR));
	wire       is_cfg   = rd_grp & ((sub4 == RD_SWF) | (sub4 == RD_HOLD));
	wire       is_exoff = (cls == CLS_AUX) & ~b4 & (sub4 == AX_EXOFF);
	wire       is_auxo  = (cls == CLS_AUX) & (sub4 == AX_OUT);
	wire       is_auxi  = (cls == CLS_AUX) & (in_byte_q[5:4] == 2'h0) &
	                      (sub4 == AX_IN);
	wire       is_def   = is_init | is_move | is_read | is_cfg |
	                      is_exoff | is_auxo | is_auxi;
	wire       exempt   = is_stop | is_auxo | is_auxi |
	                      (rd_grp & (sub4 == RD_ERR));
	wire [1:0] act      = {axis_two_active, axis_one_active};
	wire [2:0] len      = scd_len(in_byte_q);

	// ****************************************
	// Pending operand state
	// ****************************************
	scd_op_t        pend_op_q;
	logic           pend_ax_q;
	logic [7:0]     pend_code_q;
	logic [1:0][2:0] pend_left_q;
	logic [3:0][7:0] opnd_q;
	logic [1:0]     opnd_idx_q;

	wire       any_pend = (pend_left_q[0] != 3'h0) |
	                      (pend_left_q[1] != 3'h0);
	wire       last_dat = dat_ev & any_pend &
	                      (pend_left_q[pend_ax_q] == 3'h1);

	// Error precedence: pending, undefined, busy, uninitialised
	wire [3:0] cmd_err  =
		any_pend               ? ERR_WAIT   :
		!is_def                ? ERR_UNDEF  :
		(act[ax] & ~exempt)    ? ERR_BUSY   :
		(is_move & ~init_done[ax]) ? ERR_NOINIT : ERR_NONE;
	wire       accept   = cmd_ev & (cmd_err == ERR_NONE);
	wire       acc_now  = accept & (len == 3'h0);
	wire       err_set  = (cmd_ev & (cmd_err != ERR_NONE)) |
	                      (dat_ev & ~any_pend);
	wire [3:0] err_val  = cmd_ev ? cmd_err : ERR_NOCODE;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pend_op_q   <= OP_NONE;
			pend_ax_q   <= 1'b0;
			pend_code_q <= 8'h00;
			pend_left_q <= '0;
			opnd_q      <= '0;
			opnd_idx_q  <= 2'h0;
		end else if (cmd_ev & any_pend) begin
			pend_left_q <= '0;
		end else if (accept & (len != 3'h0)) begin
			pend_left_q[ax] <= len;
			pend_ax_q       <= ax;
			pend_code_q     <= in_byte_q;
			opnd_idx_q      <= 2'h0;
			pend_op_q       <= is_init ? OP_INIT :
			                   is_move ? OP_MOVE :
			                   (sub4 == RD_SWF) ? OP_SWF : OP_HOLD;
		end else if (dat_ev & any_pend) begin
			opnd_q[opnd_idx_q]         <= in_byte_q;
			opnd_idx_q                 <= opnd_idx_q + 2'h1;
			pend_left_q[pend_ax_q]     <= pend_left_q[pend_ax_q] - 3'h1;
		end
	end

	// ****************************************
	// Per-axis configuration
	// ****************************************
	logic [1:0][7:0] exc_on_q;
	logic [1:0][7:0] exc_off_q;
	logic [1:0][7:0] hold_dly_q;
	logic [1:0]      exc_en_q;

	wire commit_op = last_dat;
	wire exoff_now = acc_now & is_exoff;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			init_cfg        <= '0;
			init_start_rate <= '0;
			init_high_rate  <= '0;
			init_ramp_cnt   <= '0;
			init_done       <= 2'h0;
			exc_on_q        <= '0;
			exc_off_q       <= '0;
			hold_dly_q      <= '0;
		end else if (commit_op) begin
			case (pend_op_q)
				OP_INIT: begin
					init_cfg[pend_ax_q]        <= pend_code_q[5:0];
					init_start_rate[pend_ax_q] <= opnd_q[0];
					init_high_rate[pend_ax_q]  <= opnd_q[1];
					init_ramp_cnt[pend_ax_q]   <= {in_byte_q, opnd_q[2]};
					init_done[pend_ax_q]       <= 1'b1;
				end
				OP_SWF: begin
					exc_on_q[pend_ax_q]  <= opnd_q[0];
					exc_off_q[pend_ax_q] <= in_byte_q;
				end
				OP_HOLD: hold_dly_q[pend_ax_q] <= in_byte_q;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Move dispatch
	// ****************************************
	wire       mv_fire  = (acc_now & is_move) |
	                      (commit_op & (pend_op_q == OP_MOVE));
	wire [7:0] xc       = acc_now ? in_byte_q : pend_code_q;
	wire       xa       = xc[F_AXIS];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mv_strb  <= 2'h0;
			mv_code  <= MV_STOP;
			mv_dir   <= 1'b0;
			mv_irq   <= 1'b0;
			mv_opt   <= 1'b0;
			mv_rate  <= 8'h00;
			mv_count <= 24'h000000;
			exc_en_q <= 2'h3;
		end else begin
			mv_strb <= 2'h0;
			if (exoff_now)
				exc_en_q[ax] <= 1'b0;
			if (mv_fire) begin
				mv_strb[xa]  <= 1'b1;
				exc_en_q[xa] <= 1'b1;
				mv_code      <= xc[2:0];
				mv_dir       <= xc[F_DIR];
				mv_irq       <= xc[F_IRQ];
				mv_opt       <= (xc[2:0] == MV_RAMP || xc[2:0] == MV_HIGH) &
				                xc[F_OPT];
				mv_rate      <= 8'h00;
				mv_count     <= 24'h000000;
				case (xc[2:0])
					MV_RAMP:
						mv_count <= {in_byte_q, opnd_q[1], opnd_q[0]};
					MV_CONST: begin
						mv_rate  <= opnd_q[0];
						mv_count <= {in_byte_q, opnd_q[2], opnd_q[1]};
					end
					MV_CRUN, MV_ORIG: mv_rate <= in_byte_q;
					MV_STEP: mv_count <= 24'h000001;
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Auxiliary pins
	// ****************************************
	logic [1:0] aux_s1_q;
	logic [1:0] aux_s2_q;
	logic [1:0] aux_s3_q;
	logic [1:0] aux_in_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aux_s1_q    <= 2'h0;
			aux_s2_q    <= 2'h0;
			aux_s3_q    <= 2'h0;
			aux_in_q    <= 2'h0;
			aux_out_pin <= AUX_RST;
		end else begin
			aux_s1_q <= aux_in_pin;
			aux_s2_q <= aux_s1_q;
			aux_s3_q <= aux_s2_q;
			for (int i = 0; i < 2; i++)
				if (aux_s2_q[i] == aux_s3_q[i])
					aux_in_q[i] <= aux_s3_q[i];
			if (acc_now & is_auxo)
				aux_out_pin <= in_byte_q[5:4];
		end
	end

	// ****************************************
	// Result bytes and error register
	// ****************************************
	logic [2:0][7:0] res_q;
	logic [1:0]      res_left_q;
	logic [1:0]      res_idx_q;
	logic [3:0]      err_code_q;
	logic            err_flag_q;

	wire output_full_flag = (res_left_q != 2'h0);
	wire data_rd   = host_rd & (host_addr == ADDR_DATA);
	wire err_rd    = acc_now & rd_grp & (sub4 == RD_ERR);
	wire res_load  = acc_now & (is_read | is_auxi);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			res_q      <= '0;
			res_left_q <= 2'h0;
			res_idx_q  <= 2'h0;
			err_code_q <= ERR_NONE;
			err_flag_q <= 1'b0;
		end else begin
			if (err_set) begin
				err_flag_q <= 1'b1;
				err_code_q <= err_val;
			end else if (err_rd) begin
				err_flag_q <= 1'b0;
			end
			if (res_load) begin
				res_idx_q  <= 2'h0;
				res_left_q <= 2'h1;
				res_q      <= '0;
				if (is_auxi)
					res_q[0] <= {6'h00, aux_in_q};
				else
					case (sub4)
						RD_END: res_q[0] <= end_stat[ax];
						RD_CIN: res_q[0] <= ctl_in_stat[ax];
						RD_OUT: res_q[0] <= out_stat[ax];
						RD_REM: begin
							res_q      <= remain_cnt[ax];
							res_left_q <= 2'h3;
						end
						default: res_q[0] <= {4'h0, err_code_q};
					endcase
			end else if (data_rd & output_full_flag) begin
				res_idx_q  <= res_idx_q + 2'h1;
				res_left_q <= res_left_q - 2'h1;
			end
		end
	end

	// ****************************************
	// Host read data
	// ****************************************
	logic [7:0] status_w;

	always_comb begin
		status_w          = 8'h00;
		status_w[ST_OBF]  = output_full_flag;
		status_w[ST_IBF]  = input_full_flag;
		status_w[ST_ACT1] = axis_one_active;
		status_w[ST_ACT2] = axis_two_active;
		status_w[ST_CMD1] = (pend_left_q[0] != 3'h0);
		status_w[ST_CMD2] = (pend_left_q[1] != 3'h0);
		status_w[ST_ERR]  = err_flag_q;
	end

	wire [7:0] rd_sel = (host_addr == ADDR_CTRL) ? status_w :
	                    output_full_flag ? res_q[res_idx_q] : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			host_rdata <= 8'h00;
		else
			host_rdata <= host_rd ? rd_sel : 8'h00;
	end

	// ****************************************
	// Hold delay and excitation chopping
	// ****************************************
	logic [TICK_W-1:0] tick_cnt_q;
	logic [1:0]        act_q;
	logic [1:0]        hold_run_q;
	logic [1:0][7:0]   hold_cnt_q;
	logic [1:0][7:0]   chop_cnt_q;
	logic [1:0]        chop_ph_q;

	wire tick = (tick_cnt_q == TICK_W'(TICK_CYC - 1));

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
			act_q      <= 2'h0;
			hold_run_q <= 2'h0;
			hold_cnt_q <= '0;
			hold_out   <= 2'h0;
			chop_cnt_q <= '0;
			chop_ph_q  <= 2'h0;
		end else begin
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
			act_q      <= act;
			for (int i = 0; i < 2; i++) begin
				if (act[i]) begin
					hold_out[i]   <= 1'b0;
					hold_run_q[i] <= 1'b0;
				end else if (act_q[i]) begin
					hold_cnt_q[i] <= hold_dly_q[i];
					hold_run_q[i] <= (hold_dly_q[i] != 8'h00);
					hold_out[i]   <= (hold_dly_q[i] == 8'h00);
				end else if (hold_run_q[i] & tick) begin
					hold_cnt_q[i] <= hold_cnt_q[i] - 8'h01;
					if (hold_cnt_q[i] == 8'h01) begin
						hold_run_q[i] <= 1'b0;
						hold_out[i]   <= 1'b1;
					end
				end
				if (act[i] | (exc_off_q[i] == 8'h00)) begin
					chop_cnt_q[i] <= 8'h00;
					chop_ph_q[i]  <= 1'b0;
				end else if (tick) begin
					if (chop_cnt_q[i] + 8'h01 >=
					    (chop_ph_q[i] ? exc_off_q[i] : exc_on_q[i])) begin
						chop_cnt_q[i] <= 8'h00;
						chop_ph_q[i]  <= ~chop_ph_q[i];
					end else
						chop_cnt_q[i] <= chop_cnt_q[i] + 8'h01;
				end
			end
		end
	end

	assign phase_en = exc_en_q & (act | ~chop_ph_q);

endmodule : scd_top

// >>> test/scd_chk_sva.sv
// Purpose: Port assertions for scd_top
// Assumes: Host writes spaced at least two cycles apart
// Notes:   Attached by bind below
`timescale 1ns/1ns
module scd_chk
	import scd_pkg::*;
(
	input wire logic             ref_clk,         // Clock
	input wire logic             rst_n,           // Sync reset
	input wire logic             host_addr,       // Register select
	input wire logic [7:0]       host_wdata,      // Write byte
	input wire logic             host_wr,         // Write strobe
	input wire logic             host_rd,         // Read strobe
	input wire logic [7:0]       host_rdata,      // Read byte
	input wire logic             axis_one_active, // Axis 1 busy
	input wire logic [1:0]       aux_out_pin,     // Aux outputs
	input wire logic [1:0]       init_done,       // Configured
	input wire logic [1:0]       mv_strb,         // Move issue
	input wire logic [2:0]       mv_code,         // Move kind
	input wire logic             mv_opt,          // Output option
	input wire logic [23:0]      mv_count,        // Pulse count
	input wire logic [1:0]       phase_en         // Excitation
);
	// ****
	// Sequences
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence code_wr(v);
		host_wr && host_addr && host_wdata == v;
	endsequence
	sequence aux_wr;
		host_wr && host_addr && host_wdata[7:6] == 2'h3 &&
			host_wdata[3:0] == 4'h1;
	endsequence
	// ****
	// Assertions
	// ****
	chk_rd_idle: assert property (
		!$past(host_rd) |-> host_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_strb_src: assert property (
		mv_strb != 2'h0 |-> $past(host_wr, 2))
		else $error("move issued without a write");
	chk_one_axis: assert property (
		$onehot0(mv_strb)) else $error("both axes issued");
	chk_step_one: assert property (
		mv_strb != 2'h0 && mv_code == MV_STEP |-> mv_count == 24'h1)
		else $error("step count not one");
	chk_opt_sep: assert property (
		mv_strb != 2'h0 && mv_code != MV_RAMP && mv_code != MV_HIGH
		|-> !mv_opt) else $error("option bit leaked");
	chk_aux_set: assert property (
		aux_wr |-> ##2 aux_out_pin == $past(host_wdata[5:4], 2))
		else $error("aux output wrong");
	chk_aux_src: assert property (
		$changed(aux_out_pin) |-> $past(host_wr, 2) && $past(host_addr, 2))
		else $error("aux output changed unasked");
	chk_init_src: assert property (
		$rose(init_done[0]) || $rose(init_done[1]) |->
		$past(host_wr, 2) && !$past(host_addr, 2))
		else $error("init done without last byte");
	chk_exc_off: assert property (
		code_wr(8'hc0) ##0 !axis_one_active |-> ##2 !phase_en[0])
		else $error("excitation still on");
endmodule : scd_chk

bind scd_top scd_chk i_scd_chk (.ref_clk, .rst_n, .host_addr, .host_wdata,
	.host_wr, .host_rd, .host_rdata, .axis_one_active, .aux_out_pin,
	.init_done, .mv_strb, .mv_code, .mv_opt, .mv_count, .phase_en);

// >>> test/scd_axis_model.sv
// Purpose: Pulse generator stand-in for both axes
// Assumes: Every accepted move other than a stop runs sixteen cycles
// Notes:   Stops end the run at once
`timescale 1ns/1ns
module scd_axis_model
	import scd_pkg::*;
(
	input  wire logic             ref_clk,         // Clock
	input  wire logic             rst_n,           // Sync reset
	input  wire logic [1:0]       mv_strb,         // Move issue
	input  wire logic [2:0]       mv_code,         // Move kind
	input  wire logic [23:0]      mv_count,        // Pulse count
	output logic                  axis_one_active, // Axis 1 busy
	output logic                  axis_two_active, // Axis 2 busy
	output logic      [1:0][23:0] remain_cnt       // Pulses left
);
	logic [1:0][4:0] run_q;
	always_ff @(posedge ref_clk) begin
		for (int a = 0; a < 2; a++) begin
			if (!rst_n || (mv_strb[a] && mv_code <= MV_DSTOP)) begin
				run_q[a] <= 5'h00;
			end else if (mv_strb[a]) begin
				run_q[a] <= 5'h10;
			end else if (run_q[a] != 5'h00) begin
				run_q[a] <= run_q[a] - 5'h01;
			end
			if (!rst_n) begin
				remain_cnt[a] <= 24'h0;
			end else if (mv_strb[a] && mv_code > MV_DSTOP) begin
				remain_cnt[a] <= mv_count;
			end
		end
	end
	assign axis_one_active = run_q[0] != 5'h00;
	assign axis_two_active = run_q[1] != 5'h00;
endmodule : scd_axis_model

// >>> test/stepper_command_decoder_bench.sv
// Purpose: Self-checking bench for scd_top
// Assumes: Writes spaced two cycles, reads after result ready
// Notes:   Expected moves and read bytes queued, compared by a watcher
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
	$time, g, e); end end
module stepper_command_decoder_bench
	import scd_pkg::*;
;
	logic ref_clk = 1'b0, rst_n = 1'b0, host_addr = 1'b0;
	logic host_wr = 1'b0, host_rd = 1'b0, rd_d = 1'b0;
	logic [7:0] host_wdata = 8'h00, host_rdata, e_rd;
	logic [1:0][7:0] end_stat = '0, ctl_in_stat = '0, out_stat = '0;
	logic [1:0] aux_in_pin = 2'h0, aux_out_pin, init_done, mv_strb;
	logic [1:0] phase_en, hold_out;
	logic [1:0][5:0] init_cfg;
	logic [1:0][7:0] init_start_rate, init_high_rate;
	logic [1:0][15:0] init_ramp_cnt;
	logic [1:0][23:0] remain_cnt;
	logic [2:0] mv_code;
	logic mv_dir, mv_irq, mv_opt, axis_one_active, axis_two_active;
	logic [7:0] mv_rate;
	logic [23:0] mv_count, last_cnt;
	logic [31:0] s = 32'hb5ab4b1c, x, y;
	logic [39:0] e_mv;
	logic [7:0] rq[$];
	logic [39:0] mq[$];
	int fail_count = 0, total_checks = 0, cyc = 0, lo_cnt = 0;
	scd_top i_scd_top (.ref_clk, .rst_n, .host_addr, .host_wdata, .host_wr,
		.host_rd, .host_rdata, .axis_one_active, .axis_two_active,
		.end_stat, .ctl_in_stat, .out_stat, .remain_cnt, .aux_in_pin,
		.aux_out_pin, .init_cfg, .init_start_rate, .init_high_rate,
		.init_ramp_cnt, .init_done, .mv_strb, .mv_code, .mv_dir, .mv_irq,
		.mv_opt, .mv_rate, .mv_count, .phase_en, .hold_out);
	scd_axis_model i_scd_axis_model (.ref_clk, .rst_n, .mv_strb, .mv_code,
		.mv_count, .axis_one_active, .axis_two_active, .remain_cnt);
	// ****
	// Tasks
	// ****
	function automatic logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : rnd
	task automatic test_done();
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic wr(input logic a, input logic [7:0] d);
		@(posedge ref_clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge ref_clk);
		host_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge ref_clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge ref_clk);
		host_rd <= 1'b0;
	endtask : rd
	task automatic err(input logic [3:0] e);
		wr(1'b1, 8'h86);
		rd(1'b0, {4'h0, e});
	endtask : err
	task automatic move(input logic ax, input logic [2:0] k, input bit ok);
		logic [23:0] c;
		x = rnd();
		y = rnd();
		c = k == MV_STEP ? 24'h1 : (k == MV_RAMP || k == MV_CONST) ?
			y[23:0] : 24'h0;
		if (ok) begin
			mq.push_back({ax, !ax, k, x[2] & (k > 1), x[1] & (k > 1),
				x[0] & (k == MV_RAMP || k == MV_HIGH),
				(k == 4 || k == 5 || k == 7) ? x[15:8] : 8'h00, c});
		end
		if (ok && k > MV_DSTOP) begin
			last_cnt = c;
		end
		wr(1'b1, {x[0] & (k == 3 || k == 6), 1'b1, ax, x[1] & (k > 1),
			x[2] & (k > 1), k});
		if (k == 4 || k == 5 || k == 7) begin
			wr(1'b0, x[15:8]);
		end
		if (k == MV_RAMP || k == MV_CONST) begin
			wr(1'b0, y[7:0]);
			wr(1'b0, y[15:8]);
			wr(1'b0, y[23:16]);
		end
	endtask : move
	// ****
	// Clock, watcher, timeout
	// ****
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		rd_d <= host_rd;
		cyc++;
		if (rd_d) begin
			e_rd = rq.pop_front();
			`CHK(host_rdata, e_rd)
		end
		if (mv_strb != 2'h0) begin
			e_mv = mq.pop_front();
			`CHK({mv_strb, mv_code, mv_dir, mv_irq, mv_opt, mv_rate, mv_count}, e_mv)
		end
		if (cyc == 4000) begin
			fail_count++;
			test_done();
		end
	end
	// ****
	// Scenarios
	// ****
	initial begin
		repeat (5) @(posedge ref_clk);
		x = rnd();
		rst_n <= 1'b1;
		{end_stat, ctl_in_stat} <= x;
		out_stat <= x[15:0];
		@(posedge ref_clk);
		`CHK({aux_out_pin, phase_en, init_done}, 6'h3c)
		move(1'b0, MV_STEP, 0);
		err(4'h4);
		for (int a = 0; a < 2; a++) begin
			x = rnd();
			wr(1'b1, {2'h0, a[0], x[4:0]});
			for (int b = 1; b < 5; b++) begin
				wr(1'b0, x[8*b-1 -: 8]);
			end
			repeat (2) @(posedge ref_clk);
			`CHK({init_cfg[a], init_start_rate[a], init_high_rate[a], init_ramp_cnt[a], init_done[a]}, {a[0], x[4:0], x[7:0], x[15:8], x[31:16], 1'b1})
		end
		for (int k = 2; k < 8; k++) begin
			move(k[0], k[2:0], 1);
			repeat (20) @(posedge ref_clk);
		end
		for (int k = 0; k < 2; k++) begin
			move(1'b0, MV_RAMP, 1);
			repeat (2) @(posedge ref_clk);
			move(1'b0, MV_STEP, 0);
			err(4'h5);
			move(1'b0, k[2:0], 1);
			repeat (20) @(posedge ref_clk);
		end
		wr(1'b1, 8'h83);
		for (int b = 0; b < 3; b++) begin
			rd(1'b0, last_cnt[8*b +: 8]);
		end
		for (int i = 0; i < 3; i++) begin
			wr(1'b1, {4'ha, i[3:0]});
			rd(1'b0, i == 0 ? end_stat[1] : i == 1 ? ctl_in_stat[1] :
				out_stat[1]);
		end
		wr(1'b1, 8'h87);
		err(4'h1);
		wr(1'b0, 8'h00);
		err(4'h2);
		wr(1'b1, 8'h44);
		rd(1'b1, 8'h10);
		wr(1'b1, 8'h87);
		err(4'h3);
		for (int v = 0; v < 4; v++) begin
			wr(1'b1, {2'h3, v[1:0], 4'h1});
			repeat (2) @(posedge ref_clk);
			`CHK(aux_out_pin, v[1:0])
		end
		x = rnd();
		aux_in_pin <= x[1:0];
		repeat (6) @(posedge ref_clk);
		wr(1'b1, 8'hc2);
		rd(1'b0, {6'h00, x[1:0]});
		wr(1'b1, 8'h85);
		wr(1'b0, 8'h00);
		wr(1'b1, 8'hc0);
		repeat (2) @(posedge ref_clk);
		`CHK(phase_en[0], 1'b0)
		move(1'b0, MV_STEP, 1);
		repeat (20) @(posedge ref_clk);
		`CHK({phase_en[0], hold_out[0]}, 2'h3)
		wr(1'b1, 8'h84);
		wr(1'b0, 8'h01);
		wr(1'b0, 8'h01);
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 4 * TICK_CYC; i++) begin
			@(posedge ref_clk);
			if (phase_en[0] === 1'b0)
				lo_cnt++;
		end
		`CHK(lo_cnt, 2 * TICK_CYC)
		`CHK(mq.size() + rq.size(), 0)
		test_done();
	end
endmodule : stepper_command_decoder_bench
